// *** hw/i2cp_dev.sv ***
// Notes on behaviour
// - scl input only, sda open-drain pull-down
// - sda pulled only for read data, ack
// - bytes move msb first, bit seven first
// - answer address D6 write form, lsb direction
// - sample incoming bits on scl rising edge
// - change sda only while scl is low
// - start is sda falling while scl high
// - stop is sda rising, return to idle
// - read uses write, register, repeated start, read
// - master code 00001xxx prepares high-speed mode
// - master code is never acknowledged
// - repeated start after master code enters high-speed
// - high-speed mode held until stop
// - ack holds sda low in ninth clock
`timescale 1ns/10ps
module i2cp_dev (
    input  wire logic       link_clk,   // sampling clock of the link side
    input  wire logic       ref_clk,    // user side clock
    input  wire logic       rst,        // synchronous reset, ref_clk
    input  wire logic       clk_en,     // freezes user side state when low
    i2cp_if.dev             bus,        // i2c pins
    output logic            wr_stb,     // register write strobe
    output logic [7:0]      wr_addr,    // register written
    output logic [7:0]      wr_data,    // data written
    output logic            rd_req,     // register read request
    output logic [7:0]      rd_addr,    // register to read
    input  wire logic [7:0] rd_data,    // read data, valid cycle after rd_req
    output logic            hs_active   // bus is in high-speed mode
);
    import i2cp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // link side: reset and pin synchronisers
    logic       lrst_s1_r;
    logic       lrst_r;
    logic       scl_s1_r;
    logic       scl_s2_r;
    logic       scl_d_r;
    logic       sda_s1_r;
    logic       sda_s2_r;
    logic       sda_d_r;
    logic       atg_s1_r;
    logic       atg_s2_r;
    logic       atg_d_r;
    // read data toggle, owned by the user side and declared here for the link side synchroniser
    logic       atg_r;

    always_ff @(posedge link_clk) begin
        lrst_s1_r <= rst;
        lrst_r    <= lrst_s1_r;
        scl_s1_r  <= bus.scl;
        scl_s2_r  <= scl_s1_r;
        sda_s1_r  <= bus.sda;
        sda_s2_r  <= sda_s1_r;
    end

    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s2_r;
            sda_d_r <= sda_s2_r;
        end
    end

    wire scl_hi    = scl_s2_r && scl_d_r;
    wire start_ev  = scl_hi && sda_d_r && !sda_s2_r;
    wire stop_ev   = scl_hi && !sda_d_r && sda_s2_r;
    wire scl_rise  = !scl_d_r && scl_s2_r;
    wire scl_fall  = scl_d_r && !scl_s2_r;

    ////////////////////////////////////////////////////////////////////////
    // link side: byte engine
    i2cp_dst_e  st_r;
    i2cp_dst_e  st_nxt;
    i2cp_dst_e  ret_r;
    i2cp_dst_e  ret_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [2:0] bit_r;
    logic [2:0] bit_nxt;
    logic       full_r;
    logic       full_nxt;
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic       drv_r;
    logic       drv_nxt;
    logic       mack_r;
    logic       mack_nxt;
    logic       hsp_r;
    logic       hsp_nxt;
    logic       hs_r;
    logic       hs_nxt;
    logic       wtg_r;
    logic       wtg_nxt;
    logic [7:0] waddr_r;
    logic [7:0] waddr_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;
    logic       rtg_r;
    logic       rtg_nxt;
    logic [7:0] rdat_r;
    logic [7:0] rhold_r;

    wire addr_hit  = (sh_r[7:1] == DEV_ADDR);
    wire mcode_hit = (sh_r[7:3] == MCODE_TOP);

    always_comb begin
        st_nxt    = st_r;
        ret_nxt   = ret_r;
        sh_nxt    = sh_r;
        bit_nxt   = bit_r;
        full_nxt  = full_r;
        ptr_nxt   = ptr_r;
        drv_nxt   = drv_r;
        mack_nxt  = mack_r;
        hsp_nxt   = hsp_r;
        hs_nxt    = hs_r;
        wtg_nxt   = wtg_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        rtg_nxt   = rtg_r;
        if (stop_ev) begin
            st_nxt  = DS_IDLE;
            drv_nxt = 1'b0;
            hs_nxt  = 1'b0;
            hsp_nxt = 1'b0;
        end else if (start_ev) begin
            st_nxt   = DS_ADDR;
            bit_nxt  = 3'h0;
            full_nxt = 1'b0;
            drv_nxt  = 1'b0;
            if (hsp_r) begin
                hs_nxt  = 1'b1;
                hsp_nxt = 1'b0;
            end
        end else if (scl_rise) begin
            case (st_r)
                DS_ADDR, DS_REG, DS_WR: begin
                    sh_nxt   = {sh_r[6:0], sda_s2_r};
                    bit_nxt  = bit_r + 3'h1;
                    full_nxt = (bit_r == 3'h7);
                end
                DS_RD: begin
                    bit_nxt  = bit_r + 3'h1;
                    full_nxt = (bit_r == 3'h7);
                end
                DS_ACK: full_nxt = 1'b1;
                DS_MACK: begin
                    mack_nxt = !sda_s2_r;
                    full_nxt = 1'b1;
                end
                default: ;
            endcase
        end else if (scl_fall && full_r) begin
            full_nxt = 1'b0;
            bit_nxt  = 3'h0;
            case (st_r)
                DS_ADDR: begin
                    if (addr_hit) begin
                        drv_nxt = 1'b1;
                        st_nxt  = DS_ACK;
                        ret_nxt = sh_r[0] ? DS_RD : DS_REG;
                        if (sh_r[0]) begin
                            rtg_nxt = !rtg_r;
                        end
                    end else begin
                        st_nxt  = DS_SKIP;
                        hsp_nxt = mcode_hit;
                    end
                end
                DS_REG: begin
                    ptr_nxt = sh_r;
                    drv_nxt = 1'b1;
                    st_nxt  = DS_ACK;
                    ret_nxt = DS_WR;
                end
                DS_WR: begin
                    waddr_nxt = ptr_r;
                    wdata_nxt = sh_r;
                    wtg_nxt   = !wtg_r;
                    ptr_nxt   = ptr_r + 8'h01;
                    drv_nxt   = 1'b1;
                    st_nxt    = DS_ACK;
                    ret_nxt   = DS_WR;
                end
                DS_ACK: begin
                    st_nxt = ret_r;
                    if (ret_r == DS_RD) begin
                        sh_nxt  = rdat_r;
                        drv_nxt = !rdat_r[7];
                    end else begin
                        drv_nxt = 1'b0;
                    end
                end
                DS_RD: begin
                    drv_nxt = 1'b0;
                    st_nxt  = DS_MACK;
                    ptr_nxt = ptr_r + 8'h01;
                    rtg_nxt = !rtg_r;
                end
                DS_MACK: begin
                    if (mack_r) begin
                        sh_nxt  = rdat_r;
                        drv_nxt = !rdat_r[7];
                        st_nxt  = DS_RD;
                    end else begin
                        st_nxt  = DS_SKIP;
                    end
                end
                default: ;
            endcase
        end else if (scl_fall && st_r == DS_RD) begin
            drv_nxt = !sh_r[6];
            sh_nxt  = {sh_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            st_r    <= DS_IDLE;
            ret_r   <= DS_IDLE;
            sh_r    <= 8'h00;
            bit_r   <= 3'h0;
            full_r  <= 1'b0;
            ptr_r   <= 8'h00;
            drv_r   <= 1'b0;
            mack_r  <= 1'b0;
            hsp_r   <= 1'b0;
            hs_r    <= 1'b0;
            wtg_r   <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 8'h00;
            rtg_r   <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            ret_r   <= ret_nxt;
            sh_r    <= sh_nxt;
            bit_r   <= bit_nxt;
            full_r  <= full_nxt;
            ptr_r   <= ptr_nxt;
            drv_r   <= drv_nxt;
            mack_r  <= mack_nxt;
            hsp_r   <= hsp_nxt;
            hs_r    <= hs_nxt;
            wtg_r   <= wtg_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            rtg_r   <= rtg_nxt;
        end
    end

    // read data arrives by toggle handshake; rhold_r is stable before the toggle
    always_ff @(posedge link_clk) begin
        atg_s1_r <= atg_r;
        atg_s2_r <= atg_s1_r;
        if (lrst_r) begin
            atg_d_r <= 1'b0;
            rdat_r  <= 8'h00;
        end else begin
            atg_d_r <= atg_s2_r;
            if (atg_s2_r != atg_d_r) begin
                rdat_r <= rhold_r;
            end
        end
    end

    assign bus.sda_dev_o  = 1'b0;
    assign bus.sda_dev_oe = drv_r;

    ////////////////////////////////////////////////////////////////////////
    // user side
    logic wtg_s1_r;
    logic wtg_s2_r;
    logic wtg_d_r;
    logic rtg_s1_r;
    logic rtg_s2_r;
    logic rtg_d_r;
    logic hs_s1_r;
    logic rd_pend_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wtg_s1_r  <= 1'b0;
            wtg_s2_r  <= 1'b0;
            wtg_d_r   <= 1'b0;
            rtg_s1_r  <= 1'b0;
            rtg_s2_r  <= 1'b0;
            rtg_d_r   <= 1'b0;
            hs_s1_r   <= 1'b0;
            hs_active <= 1'b0;
            wr_stb    <= 1'b0;
            wr_addr   <= 8'h00;
            wr_data   <= 8'h00;
            rd_req    <= 1'b0;
            rd_addr   <= 8'h00;
            rd_pend_r <= 1'b0;
            rhold_r   <= 8'h00;
            atg_r     <= 1'b0;
        end else if (clk_en) begin
            wtg_s1_r  <= wtg_r;
            wtg_s2_r  <= wtg_s1_r;
            wtg_d_r   <= wtg_s2_r;
            rtg_s1_r  <= rtg_r;
            rtg_s2_r  <= rtg_s1_r;
            rtg_d_r   <= rtg_s2_r;
            hs_s1_r   <= hs_r;
            hs_active <= hs_s1_r;
            wr_stb    <= wtg_s2_r ^ wtg_d_r;
            rd_req    <= rtg_s2_r ^ rtg_d_r;
            rd_pend_r <= rd_req;
            if (wtg_s2_r ^ wtg_d_r) begin
                wr_addr <= waddr_r;
                wr_data <= wdata_r;
            end
            if (rtg_s2_r ^ rtg_d_r) begin
                rd_addr <= ptr_r;
            end
            if (rd_pend_r) begin
                rhold_r <= rd_data;
                atg_r   <= !atg_r;
            end
        end
    end
endmodule : i2cp_dev

// *** include/i2cp_pkg.sv ***
package i2cp_pkg;
    // target address, 8-bit write form D6
    localparam logic [6:0] DEV_ADDR   = 7'h6B;
    // high-speed master code 00001xxx, upper five bits
    localparam logic [4:0] MCODE_TOP  = 5'h01;
    localparam logic [2:0] MCODE_LOW  = 3'h0;

    localparam int         REF_CLK_HZ = 100_000_000;
    // master-code and low-speed rate, at most 1 MHz
    localparam int         FS_SCL_HZ  = 400_000;
    // high-speed rate, at most 3.4 MHz, kept low enough for the 80 ns sampler
    localparam int         HS_SCL_HZ  = 1_500_000;
    // quarter of an scl period in ref_clk cycles, rounded up so the rate stays under its limit
    localparam logic [7:0] FS_QTR     = 8'((REF_CLK_HZ + 4 * FS_SCL_HZ - 1) / (4 * FS_SCL_HZ));
    localparam logic [7:0] HS_QTR     = 8'((REF_CLK_HZ + 4 * HS_SCL_HZ - 1) / (4 * HS_SCL_HZ));

    localparam logic [3:0] STEP_STOP  = 4'h8;

    typedef enum logic [2:0] {
        DS_IDLE = 3'b000,
        DS_ADDR = 3'b001,
        DS_REG  = 3'b010,
        DS_WR   = 3'b011,
        DS_ACK  = 3'b100,
        DS_RD   = 3'b101,
        DS_MACK = 3'b110,
        DS_SKIP = 3'b111
    } i2cp_dst_e;

    typedef enum logic [2:0] {
        OP_SKIP   = 3'b000,
        OP_START  = 3'b001,
        OP_TX     = 3'b010,
        OP_RX     = 3'b011,
        OP_STOP   = 3'b100,
        OP_END    = 3'b101
    } i2cp_op_e;
endpackage : i2cp_pkg

// *** include/i2cp_if.sv ***
`timescale 1ns/10ps
interface i2cp_if;
    logic scl;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda;

    // wired-and of the two open-drain drivers with a pull-up
    assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));

    modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface : i2cp_if

// *** hw/i2cp_host.sv ***
`timescale 1ns/10ps
module i2cp_host (
    input  wire logic       ref_clk,    // host clock, scl is divided from it
    input  wire logic       rst,        // synchronous reset
    input  wire logic       clk_en,     // freezes all state when low
    i2cp_if.host            bus,        // i2c pins
    input  wire logic       cmd_valid,  // start a transfer
    input  wire logic       cmd_rd,     // 1 read, 0 write
    input  wire logic       cmd_hs,     // enter high-speed mode first
    input  wire logic [7:0] cmd_reg,    // register address
    input  wire logic [7:0] cmd_wdata,  // write data
    output logic            cmd_ready,  // idle, command accepted
    output logic            done,       // transfer finished
    output logic            nack,       // last transfer saw a nack
    output logic [7:0]      rdata       // data of last read
);
    import i2cp_pkg::*;

    // transfer script, one operation per step
    function automatic i2cp_op_e step_op(input logic [3:0] s, input logic rd, input logic hs);
        case (s)
            4'h0:    step_op = hs ? OP_START : OP_SKIP;
            4'h1:    step_op = hs ? OP_TX : OP_SKIP;
            4'h2:    step_op = OP_START;
            4'h3:    step_op = OP_TX;
            4'h4:    step_op = OP_TX;
            4'h5:    step_op = rd ? OP_START : OP_TX;
            4'h6:    step_op = rd ? OP_TX : OP_SKIP;
            4'h7:    step_op = rd ? OP_RX : OP_SKIP;
            4'h8:    step_op = OP_STOP;
            default: step_op = OP_END;
        endcase
    endfunction : step_op

    function automatic logic [7:0] step_byte(input logic [3:0] s, input logic [7:0] rg, input logic [7:0] wd);
        case (s)
            4'h1:    step_byte = {MCODE_TOP, MCODE_LOW};
            4'h3:    step_byte = {DEV_ADDR, 1'b0};
            4'h4:    step_byte = rg;
            4'h5:    step_byte = wd;
            default: step_byte = {DEV_ADDR, 1'b1};
        endcase
    endfunction : step_byte

    logic       sda_s1_r;
    logic       sda_s2_r;
    logic       busy_r;
    logic [3:0] step_r;
    logic [7:0] q_r;
    logic [1:0] ph_r;
    logic [3:0] bit_r;
    logic       hsr_r;
    logic       scl_r;
    logic       oe_r;
    logic [8:0] sh_r;
    logic       rd_r;
    logic       hs_r;
    logic [7:0] reg_r;
    logic [7:0] wd_r;

    wire i2cp_op_e   op_w   = step_op(step_r, rd_r, hs_r);
    wire logic [7:0] byte_w = step_byte(step_r, reg_r, wd_r);
    wire logic [7:0] qtr_w  = hsr_r ? HS_QTR : FS_QTR;
    wire logic       txb_w  = byte_w[3'(3'h7 - bit_r[2:0])];
    wire logic       tick_w = busy_r && (op_w != OP_SKIP) && (op_w != OP_END) && (q_r == 8'h00);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
        end else if (clk_en) begin
            sda_s1_r <= bus.sda;
            sda_s2_r <= sda_s1_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy_r <= 1'b0; step_r <= 4'h0; q_r <= 8'h00; ph_r <= 2'h0; bit_r <= 4'h0;
            hsr_r <= 1'b0; scl_r <= 1'b1; oe_r <= 1'b0; sh_r <= 9'h000;
            rd_r <= 1'b0; hs_r <= 1'b0; reg_r <= 8'h00; wd_r <= 8'h00;
            cmd_ready <= 1'b0; done <= 1'b0; nack <= 1'b0; rdata <= 8'h00;
        end else if (clk_en) begin
            done      <= 1'b0;
            cmd_ready <= !busy_r && !cmd_valid;
            if (!busy_r) begin
                if (cmd_valid) begin
                    busy_r <= 1'b1; step_r <= 4'h0; ph_r <= 2'h0; bit_r <= 4'h0; q_r <= FS_QTR;
                    rd_r <= cmd_rd; hs_r <= cmd_hs; reg_r <= cmd_reg; wd_r <= cmd_wdata; nack <= 1'b0;
                end
            end else if (op_w == OP_SKIP) begin
                step_r <= step_r + 4'h1;
            end else if (op_w == OP_END) begin
                busy_r <= 1'b0;
                done   <= 1'b1;
            end else if (!tick_w) begin
                q_r <= q_r - 8'h01;
            end else begin
                q_r  <= qtr_w;
                ph_r <= ph_r + 2'h1;
                case (ph_r)
                    2'h0: begin
                        // data changes only while scl is low
                        if (op_w == OP_STOP) oe_r <= 1'b1;
                        else if (op_w == OP_TX && bit_r < 4'h8) oe_r <= !txb_w;
                        else oe_r <= 1'b0;
                    end
                    2'h1: scl_r <= 1'b1;
                    2'h2: begin
                        if (op_w == OP_START) oe_r <= 1'b1;
                        else if (op_w == OP_STOP) oe_r <= 1'b0;
                        else sh_r <= {sh_r[7:0], sda_s2_r};
                    end
                    default: begin
                        if (op_w == OP_STOP) begin
                            hsr_r  <= 1'b0;
                            step_r <= step_r + 4'h1;
                        end else if (op_w == OP_START) begin
                            scl_r  <= 1'b0;
                            step_r <= step_r + 4'h1;
                            // repeated start after the master code switches the rate
                            if (hs_r && step_r == 4'h2) hsr_r <= 1'b1;
                        end else begin
                            scl_r <= 1'b0;
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == 4'h8) begin
                                bit_r  <= 4'h0;
                                oe_r   <= 1'b0;
                                step_r <= step_r + 4'h1;
                                if (op_w == OP_RX) rdata <= sh_r[8:1];
                                // a nack other than on the master code aborts to stop
                                if (op_w == OP_TX && sh_r[0] && step_r != 4'h1) begin
                                    nack   <= 1'b1;
                                    step_r <= STEP_STOP;
                                end
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign bus.scl         = scl_r;
    assign bus.sda_host_o  = 1'b0;
    assign bus.sda_host_oe = oe_r;
endmodule : i2cp_host

// *** sim/i2cp_props.sv ***
`timescale 1ns/10ps
module i2cp_props (
    input wire logic link_clk,   // sampling clock
    input wire logic rst,        // reset
    input wire logic scl,        // bus clock
    input wire logic sda,        // resolved data
    input wire logic sda_dev_o,  // device level
    input wire logic sda_dev_oe  // device pull
);
    import i2cp_pkg::*;
    logic       scl_d_r, sda_d_r, first_r, ign_r;
    logic [3:0] bc_r;
    logic [7:0] sh_r;
    wire        st     = scl && scl_d_r && sda_d_r && !sda;
    wire        sp     = scl && scl_d_r && !sda_d_r && sda;
    wire        rise   = scl && !scl_d_r;
    wire        last   = rise && first_r && bc_r == 4'h8;
    wire [3:0]  bc_nxt = (bc_r == 4'h8) ? 4'h0 : bc_r + 4'h1;
    always_ff @(posedge link_clk) begin
        scl_d_r <= scl;
        sda_d_r <= sda;
    end
    // bit count and first byte after each start
    always_ff @(posedge link_clk) begin
        if (rst || st || sp) begin
            bc_r <= 4'h0;
            first_r <= st;
            ign_r <= 1'b0;
        end else if (rise) begin
            bc_r <= bc_nxt;
            if (bc_r != 4'h8) sh_r <= {sh_r[6:0], sda};
            first_r <= first_r && bc_r != 4'h8;
            ign_r <= ign_r || (last && sh_r[7:1] != DEV_ADDR);
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge link_clk); endclocking
    default disable iff (rst);
    property p_od; sda_dev_oe |-> !sda_dev_o; endproperty
    a_od: assert property (p_od) else $error("device drove sda high");
    property p_chg; $changed(sda_dev_oe) |-> !scl; endproperty
    a_chg: assert property (p_chg) else $error("device moved sda with scl high");
    property p_hold; scl && $past(scl) && $past(sda_dev_oe) |-> sda_dev_oe; endproperty
    a_hold: assert property (p_hold) else $error("device let go while scl high");
    property p_addr; last && sh_r[7:1] == DEV_ADDR |-> sda_dev_oe; endproperty
    a_addr: assert property (p_addr) else $error("own address not acked");
    property p_mcode; last && sh_r[7:3] == 5'h01 |-> !sda_dev_oe; endproperty
    a_mcode: assert property (p_mcode) else $error("master code acked");
    property p_ign; ign_r |-> !sda_dev_oe; endproperty
    a_ign: assert property (p_ign) else $error("sda pulled for other target");
    property p_aph; first_r && bc_r inside {[1:7]} |-> !sda_dev_oe; endproperty
    a_aph: assert property (p_aph) else $error("sda pulled in address byte");
    property p_start; scl && $past(scl) && $fell(sda) |-> ##[1:40] !scl; endproperty
    a_start: assert property (p_start) else $error("no clock after start");
endmodule : i2cp_props

// *** sim/tb.sv ***
`timescale 1ns/10ps
module tb;
    logic       ref_clk = 0, link_clk = 0, rst = 1, clk_en = 1;
    logic       cmd_valid = 0, cmd_rd = 0, cmd_hs = 0, cmd_ready, done, nack;
    logic [7:0] cmd_reg = 0, cmd_wdata = 0, rdata, rd_data = 0, wr_addr, wr_data, rd_addr;
    logic [7:0] last_wd, sh, mem [256];
    logic [7:0] hb [$];
    logic       wr_stb, rd_req, hs_active, seen_hs = 0, dev2_drove = 0;
    int         n_fail = 0, checks_done = 0, cyc = 0, nb = 9;
    i2cp_if bus ();
    i2cp_if bus2 ();
    i2cp_dev i2cp_dev_i (.link_clk, .ref_clk, .rst, .clk_en, .bus(bus.dev), .wr_stb, .wr_addr, .wr_data,
        .rd_req, .rd_addr, .rd_data, .hs_active);
    i2cp_dev i2cp_dev_i2 (.link_clk, .ref_clk, .rst, .clk_en, .bus(bus2.dev), .wr_stb(), .wr_addr(),
        .wr_data(), .rd_req(), .rd_addr(), .rd_data, .hs_active());
    i2cp_host i2cp_host_i (.ref_clk, .rst, .clk_en, .bus(bus.host), .cmd_valid, .cmd_rd, .cmd_hs, .cmd_reg,
        .cmd_wdata, .cmd_ready, .done, .nack, .rdata);
    i2cp_props i2cp_props_i (.link_clk, .rst, .scl(bus.scl), .sda(bus.sda), .sda_dev_o(bus.sda_dev_o),
        .sda_dev_oe(bus.sda_dev_oe));
    always #5 ref_clk = ~ref_clk;
    initial begin
        #17;
        forever #40 link_clk = ~link_clk;
    end
    ////////////////////////////////////////
    always @(posedge ref_clk) begin
        cyc++;
        rd_data <= #1 mem[rd_addr];
        if (wr_stb === 1'b1) mem[wr_addr] = wr_data;
        if (wr_stb === 1'b1) last_wd = wr_data;
        if (hs_active === 1'b1) seen_hs = 1;
        if (bus2.sda_dev_oe === 1'b1) dev2_drove = 1;
        if (cyc == 80000) begin
            n_fail++;
            summarize();
        end
    end
    // first byte after every start, as seen on the wire
    always @(negedge bus.sda) if (bus.scl === 1'b1) nb = 0;
    always @(posedge bus.scl) if (nb < 8) begin
        sh = {sh[6:0], bus.sda};
        nb++;
        if (nb == 8) hb.push_back(sh);
    end
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wt
    task automatic run(input logic rd, input logic hs, input logic [7:0] r, input logic [7:0] w);
        int k;
        hb.delete();
        seen_hs = 0;
        cmd_rd = rd;
        cmd_hs = hs;
        cmd_reg = r;
        cmd_wdata = w;
        cmd_valid = 1;
        wt(1);
        cmd_valid = 0;
        k = 0;
        while (done !== 1'b1 && k < 40000) begin
            wt(1);
            k++;
        end
        chk(k < 40000, "no done");
        wt(1);
        chk(cmd_ready === 1'b1, "host not idle after done");
    endtask : run
    // bench bit-banging on the second bus
    task automatic bb(input logic b, output logic s);
        bus2.sda_host_oe = !b;
        wt(40);
        bus2.scl = 1;
        wt(20);
        s = bus2.sda;
        wt(20);
        bus2.scl = 0;
        wt(4);
    endtask : bb
    task automatic bbyte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bb(v[i], s);
        bb(1'b1, s);
        ack = !s;
    endtask : bbyte
    task automatic cond(input logic st);
        bus2.sda_host_oe = !st;
        wt(40);
        bus2.scl = 1;
        wt(40);
        bus2.sda_host_oe = st;
        wt(40);
        if (st) bus2.scl = 0;
        wt(4);
    endtask : cond
    task automatic t_write;
        run(0, 0, 8'h10, 8'hC1);
        chk(hb.size() == 1 && hb[0] === 8'hD6, "address byte");
        chk(mem[8'h10] === 8'hC1 && nack === 1'b0, "write");
        chk(bus.scl === 1'b1 && bus.sda === 1'b1, "bus not idle");
    endtask : t_write
    task automatic t_read;
        run(1, 0, 8'h10, 8'h00);
        chk(hb.size() == 2 && hb[0] === 8'hD6 && hb[1] === 8'hD7, "read framing");
        chk(rdata === 8'hC1 && nack === 1'b0, "read data");
    endtask : t_read
    task automatic t_hs;
        int k;
        run(0, 1, 8'h22, 8'h3C);
        chk(hb.size() == 2 && hb[0][7:3] === 5'h01 && hb[1] === 8'hD6, "hs entry");
        chk(seen_hs === 1'b1 && nack === 1'b0 && last_wd === 8'h3C, "hs write");
        run(1, 1, 8'h22, 8'h00);
        chk(hb.size() == 3 && hb[2] === 8'hD7 && rdata === 8'h3C, "hs read");
        k = 0;
        while (hs_active !== 1'b0 && k < 200) begin
            wt(1);
            k++;
        end
        chk(hs_active === 1'b0, "hs kept after stop");
    endtask : t_hs
    task automatic t_foreign;
        logic a;
        dev2_drove = 0;
        cond(1);
        bbyte(8'hA0, a);
        chk(a === 1'b0, "other address acked");
        bbyte(8'h00, a);
        cond(0);
        chk(dev2_drove === 1'b0, "sda pulled for other target");
        cond(1);
        bbyte(8'hD6, a);
        chk(a === 1'b1, "own address not acked");
        bbyte(8'h05, a);
        chk(a === 1'b1, "register byte not acked");
        cond(0);
    endtask : t_foreign
    task automatic summarize;
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    initial begin
        foreach (mem[i]) mem[i] = 8'(i);
        bus2.scl = 1;
        bus2.sda_host_o = 0;
        bus2.sda_host_oe = 0;
        repeat (8) @(posedge link_clk);
        @(posedge ref_clk);
        #1 rst = 0;
        wt(40);
        t_write();
        t_read();
        t_hs();
        t_foreign();
        summarize();
    end
endmodule : tb
